//--- src/gen_ctrl_pkg.sv
// Constants, register map and field layout of the general control and event register group
package gen_ctrl_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_GENERAL_CONTROL = 8'h86;
    localparam logic [7:0] IDX_EVENT_STATUS    = 8'h88;
    localparam logic [7:0] IDX_EVENT_ENABLE    = 8'h89;
    localparam logic [7:0] IDX_INPUT_LEVELS    = 8'h8A;
    localparam logic [7:0] IDX_PIN_SELECT      = 8'h90;

    // Bus geometry
    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;

    // General control field layout
    localparam int         ARB_LSB        = 0;
    localparam int         CTRL_OFF_BIT   = 3;
    localparam int         SWITCH_BIT     = 10;
    localparam logic [15:0] GEN_CTRL_MASK = 16'h040B;
    localparam logic [15:0] GEN_CTRL_RST  = 16'h0000;

    // Event register layout
    localparam int        POWER_BIT       = 7;
    localparam int        PROG_BIT        = 6;
    localparam logic [7:0] EVENT_MASK     = 8'hDF;
    localparam logic [7:0] EVENT_RST      = 8'h00;
    localparam logic [4:0] LEVELS_RST     = 5'h00;

    // Pin select register: one nibble per pin 0, 1, 2, 4, 5
    localparam int         SEL_W          = 4;
    localparam int         SEL_PINS       = 5;
    localparam logic [3:0] SEL_GP_INPUT   = 4'h0;
    localparam logic [3:0] SEL_EVENT_OUT  = 4'hE;
    localparam logic [19:0] PIN_SELECT_RST = 20'h00000;

    // Arbitration modes
    typedef enum logic [1:0] {
        ARB_HOST_FIRST = 2'b00,
        ARB_CARD_FIRST = 2'b01,
        ARB_FAIR_A     = 2'b10,
        ARB_FAIR_B     = 2'b11
    } arb_mode_t;

endpackage : gen_ctrl_pkg

//--- src/general_control_and_event_regs.sv
// General control, event status/enable and input level registers on an Avalon-MM slave
//
// The Avalon-MM register port is this design's own decision.
module general_control_and_event_regs
    import gen_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic                           clk,
    input  wire logic                           reset_n,
    // Avalon-MM register slave
    input  wire logic [gen_ctrl_pkg::ADDR_W-1:0] address,
    input  wire logic                           read,
    input  wire logic                           write,
    input  wire logic [3:0]                     byteenable,
    input  wire logic [gen_ctrl_pkg::DATA_W-1:0] writedata,
    output logic      [gen_ctrl_pkg::DATA_W-1:0] readdata,
    output logic                                waitrequest,
    // Software supply-change notices from the socket power logic
    input  wire logic                           power_state_change,
    input  wire logic                           prog_supply_change,
    // Arbitration requests and grants
    input  wire logic                           host_ctrl_req,
    input  wire logic                           card_bus_req,
    output logic                                host_ctrl_gnt,
    output logic                                card_bus_gnt,
    // Control levels to the rest of the chip
    output logic [1:0]                          arbitration_select,
    output logic                                host_controller_off,
    output logic                                host_controller_enable,
    output logic                                power_switch_type,
    // Multifunction pins
    input  wire logic                           multi_pin_0,
    input  wire logic                           multi_pin_1,
    input  wire logic                           multi_pin_2,
    input  wire logic                           multi_pin_4,
    input  wire logic                           multi_pin_5,
    output logic                                multi_pin_2_out,
    output logic                                multi_pin_2_oe_n,
    output logic                                multi_pin_4_out,
    output logic                                multi_pin_4_oe_n,
    output logic                                multi_pin_5_out,
    output logic                                multi_pin_5_oe_n,
    // Active-low event output
    output logic                                event_out_n
);

    // Merge one byte lane of write data into an old value
    function automatic logic [7:0] lane_merge(input logic [7:0] old_val,
                                              input logic [7:0] new_val,
                                              input logic       lane_on);
        lane_merge = lane_on ? new_val : old_val;
    endfunction : lane_merge

    // Register state
    logic                    ack_reg,          ack_next;
    logic [DATA_W-1:0]       rdata_reg,        rdata_next;
    logic [15:0]             gen_ctrl_reg,     gen_ctrl_next;
    logic [7:0]              status_reg,       status_next;
    logic [7:0]              enable_reg,       enable_next;
    logic [19:0]             pin_sel_reg,      pin_sel_next;
    logic [4:0]              level_reg,        level_next;
    logic [4:0]              prev_level_reg,   prev_level_next;
    logic                    primed_reg,       primed_next;
    logic                    event_n_reg,      event_n_next;
    logic                    rr_last_host_reg, rr_last_host_next;
    logic                    hgnt_reg,         hgnt_next;
    logic                    cgnt_reg,         cgnt_next;

    // Decode helpers
    logic                    req;
    logic                    wr_take;
    logic [7:0]              index;
    logic                    word_ok;
    logic [4:0]              pins_now;
    logic [4:0]              is_input;
    logic [4:0]              input_events;
    logic [7:0]              set_events;
    logic [7:0]              clear_bits;
    logic                    host_req_ok;
    arb_mode_t               mode;

    assign req         = read | write;
    assign index       = address[ADDR_W-1:2];
    assign word_ok     = (address[1:0] == 2'b00);
    assign wr_take     = write & ack_reg & word_ok;
    assign waitrequest = req & ~ack_reg;
    assign pins_now    = {multi_pin_5, multi_pin_4, multi_pin_2, multi_pin_1, multi_pin_0};
    assign mode        = arb_mode_t'(gen_ctrl_reg[ARB_LSB +: 2]);
    assign host_req_ok = host_ctrl_req & ~gen_ctrl_reg[CTRL_OFF_BIT];

    // Per-pin general-purpose input configuration
    always_comb begin
        for (int i = 0; i < SEL_PINS; i++) begin
            is_input[i] = (pin_sel_reg[i*SEL_W +: SEL_W] == SEL_GP_INPUT);
        end
    end

    // Bus handshake: answer one cycle after the request is seen
    always_comb begin
        ack_next = req & ~ack_reg;
    end

    // Read data is captured in the wait cycle and stands at the accepting edge
    always_comb begin
        rdata_next = rdata_reg;
        if (req & ~ack_reg) begin
            rdata_next = '0;
            if (read & word_ok) begin
                unique case (index)
                    IDX_GENERAL_CONTROL: rdata_next[15:0] = gen_ctrl_reg & GEN_CTRL_MASK;
                    IDX_EVENT_STATUS:    rdata_next[7:0]  = status_reg & EVENT_MASK;
                    IDX_EVENT_ENABLE:    rdata_next[7:0]  = enable_reg & EVENT_MASK;
                    IDX_INPUT_LEVELS:    rdata_next[7:0]  = {3'h0, level_reg};
                    IDX_PIN_SELECT:      rdata_next[19:0] = pin_sel_reg;
                    default:             rdata_next       = '0;
                endcase
            end
        end
    end

    // Software-writable control registers
    always_comb begin
        gen_ctrl_next = gen_ctrl_reg;
        enable_next   = enable_reg;
        pin_sel_next  = pin_sel_reg;
        clear_bits    = 8'h00;
        if (wr_take) begin
            unique case (index)
                IDX_GENERAL_CONTROL: begin
                    gen_ctrl_next[7:0]  = lane_merge(gen_ctrl_reg[7:0], writedata[7:0],
                                                     byteenable[0]);
                    gen_ctrl_next[15:8] = lane_merge(gen_ctrl_reg[15:8], writedata[15:8],
                                                     byteenable[1]);
                    gen_ctrl_next       = gen_ctrl_next & GEN_CTRL_MASK;
                end
                IDX_EVENT_STATUS: begin
                    clear_bits = byteenable[0] ? (writedata[7:0] & EVENT_MASK) : 8'h00;
                end
                IDX_EVENT_ENABLE: begin
                    enable_next = lane_merge(enable_reg, writedata[7:0], byteenable[0])
                                  & EVENT_MASK;
                end
                IDX_PIN_SELECT: begin
                    pin_sel_next[7:0]   = lane_merge(pin_sel_reg[7:0], writedata[7:0],
                                                     byteenable[0]);
                    pin_sel_next[15:8]  = lane_merge(pin_sel_reg[15:8], writedata[15:8],
                                                     byteenable[1]);
                    pin_sel_next[19:16] = byteenable[2] ? writedata[19:16] : pin_sel_reg[19:16];
                end
                default: begin
                    clear_bits = 8'h00;   // Input levels and unmapped words ignore writes
                end
            endcase
        end
    end

    // Input sampling and change detection
    always_comb begin
        level_next      = pins_now;
        // Until the first sample is in, the old level copies the pins so no false edge follows reset
        prev_level_next = primed_reg ? level_reg : pins_now;
        primed_next     = 1'b1;
        input_events    = primed_reg ? ((level_reg ^ prev_level_reg) & is_input) : 5'h00;
    end

    // Sticky event status: set wins over a simultaneous clear
    always_comb begin
        set_events            = 8'h00;
        set_events[POWER_BIT] = power_state_change;
        set_events[PROG_BIT]  = prog_supply_change;
        set_events[4:0]       = input_events;
        status_next = ((status_reg & ~clear_bits) | set_events) & EVENT_MASK;
    end

    // Event output: low while any enabled pair is set
    always_comb begin
        event_n_next = ~|(status_next & enable_next);
    end

    // Top-level arbiter between host controller and card bus
    always_comb begin
        hgnt_next         = 1'b0;
        cgnt_next         = 1'b0;
        rr_last_host_next = rr_last_host_reg;
        if (host_req_ok && card_bus_req) begin
            unique case (mode)
                ARB_HOST_FIRST: hgnt_next = 1'b1;
                ARB_CARD_FIRST: cgnt_next = 1'b1;
                ARB_FAIR_A, ARB_FAIR_B: begin
                    hgnt_next = ~rr_last_host_reg;
                    cgnt_next = rr_last_host_reg;
                end
            endcase
        end else begin
            hgnt_next = host_req_ok;
            cgnt_next = card_bus_req;
        end
        if (hgnt_next) begin
            rr_last_host_next = 1'b1;
        end else if (cgnt_next) begin
            rr_last_host_next = 1'b0;
        end
    end

    // Register all state
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ack_reg          <= 1'b0;
            rdata_reg        <= '0;
            gen_ctrl_reg     <= GEN_CTRL_RST;
            status_reg       <= EVENT_RST;
            enable_reg       <= EVENT_RST;
            pin_sel_reg      <= PIN_SELECT_RST;
            level_reg        <= LEVELS_RST;
            prev_level_reg   <= LEVELS_RST;
            primed_reg       <= 1'b0;
            event_n_reg      <= 1'b1;
            rr_last_host_reg <= 1'b0;
            hgnt_reg         <= 1'b0;
            cgnt_reg         <= 1'b0;
        end else begin
            ack_reg          <= ack_next;
            rdata_reg        <= rdata_next;
            gen_ctrl_reg     <= gen_ctrl_next;
            status_reg       <= status_next;
            enable_reg       <= enable_next;
            pin_sel_reg      <= pin_sel_next;
            level_reg        <= level_next;
            prev_level_reg   <= prev_level_next;
            primed_reg       <= primed_next;
            event_n_reg      <= event_n_next;
            rr_last_host_reg <= rr_last_host_next;
            hgnt_reg         <= hgnt_next;
            cgnt_reg         <= cgnt_next;
        end
    end

    // Outputs
    assign readdata               = rdata_reg;
    assign host_ctrl_gnt          = hgnt_reg;
    assign card_bus_gnt           = cgnt_reg;
    assign arbitration_select     = gen_ctrl_reg[ARB_LSB +: 2];
    assign host_controller_off    = gen_ctrl_reg[CTRL_OFF_BIT];
    assign host_controller_enable = ~gen_ctrl_reg[CTRL_OFF_BIT];
    assign power_switch_type      = gen_ctrl_reg[SWITCH_BIT];
    assign event_out_n            = event_n_reg;

    // Pins 2, 4 and 5 routed to the event output drive it; others stay inputs
    assign multi_pin_2_out  = event_n_reg;
    assign multi_pin_4_out  = event_n_reg;
    assign multi_pin_5_out  = event_n_reg;
    assign multi_pin_2_oe_n = ~(pin_sel_reg[2*SEL_W +: SEL_W] == SEL_EVENT_OUT);
    assign multi_pin_4_oe_n = ~(pin_sel_reg[3*SEL_W +: SEL_W] == SEL_EVENT_OUT);
    assign multi_pin_5_oe_n = ~(pin_sel_reg[4*SEL_W +: SEL_W] == SEL_EVENT_OUT);

endmodule : general_control_and_event_regs

//--- tb/general_control_and_event_regs_assertions.sv
// Port-level checks of the general control and event register group
module general_control_and_event_regs_assertions (
    // Clock, reset and register bus
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic [9:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    // Arbitration and control levels
    input wire logic        host_ctrl_req,
    input wire logic        card_bus_req,
    input wire logic        host_ctrl_gnt,
    input wire logic        card_bus_gnt,
    input wire logic [1:0]  arbitration_select,
    input wire logic        host_controller_off,
    input wire logic        host_controller_enable,
    input wire logic        power_switch_type,
    // Event output and its pin
    input wire logic        multi_pin_5_out,
    input wire logic        multi_pin_5_oe_n,
    input wire logic        event_out_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Accepted bus cycles and contended requests
    sequence s_wr(a); write && !waitrequest && address == a; endsequence
    sequence s_rd(a); read && !waitrequest && address == a; endsequence
    sequence s_both; host_ctrl_req && card_bus_req && !host_controller_off; endsequence
    // Bus answers after one wait state
    chk_bus_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("bus request kept waiting");
    chk_arb_host_first: assert property (s_both ##0 arbitration_select == 2'h0 |=> host_ctrl_gnt && !card_bus_gnt)
        else $error("host side not favoured");
    chk_arb_card_first: assert property (s_both ##0 arbitration_select == 2'h1 |=> card_bus_gnt && !host_ctrl_gnt)
        else $error("card side not favoured");
    chk_off_no_grant: assert property (host_controller_off |=> !host_ctrl_gnt)
        else $error("grant while controller off");
    chk_off_enable_pair: assert property (host_controller_enable != host_controller_off)
        else $error("enable not inverse of off");
    chk_switch_type_write: assert property (s_wr(10'h218) |=> power_switch_type == $past(writedata[10]))
        else $error("switch type not taken");
    chk_ctrl_reserved_zero: assert property (s_rd(10'h218) |-> (readdata & ~32'h0000040B) == 32'h0)
        else $error("reserved control bits set");
    chk_event_bit5_zero: assert property (s_rd(10'h220) or s_rd(10'h224) |-> readdata[31:8] == 24'h0 && !readdata[5])
        else $error("event reserved bits set");
    chk_levels_upper_zero: assert property (s_rd(10'h228) |-> readdata[31:5] == 27'h0)
        else $error("input upper bits set");
    chk_pin5_event_drive: assert property (!multi_pin_5_oe_n |-> multi_pin_5_out == event_out_n)
        else $error("pin 5 not carrying event");
    chk_event_held_low: assert property (!event_out_n && !(write && !waitrequest) |=> !event_out_n)
        else $error("event released without a write");
endmodule : general_control_and_event_regs_assertions

bind general_control_and_event_regs general_control_and_event_regs_assertions u_chk (.*);

//--- tb/gen_pins_model.sv
// Outside world of the multifunction pins, resolved against the design's own drive
module gen_pins_model (
    // Levels presented for pins 0, 1, 2, 4 and 5
    input  wire logic [4:0] level,
    // Design drive of the two-way pins
    input  wire logic       multi_pin_2_out,
    input  wire logic       multi_pin_2_oe_n,
    input  wire logic       multi_pin_4_out,
    input  wire logic       multi_pin_4_oe_n,
    input  wire logic       multi_pin_5_out,
    input  wire logic       multi_pin_5_oe_n,
    // Resolved pin levels seen by the design
    output logic            multi_pin_0,
    output logic            multi_pin_1,
    output logic            multi_pin_2,
    output logic            multi_pin_4,
    output logic            multi_pin_5
);
    // Design wins the wire while its enable is low
    assign multi_pin_0 = level[0];
    assign multi_pin_1 = level[1];
    assign multi_pin_2 = multi_pin_2_oe_n ? level[2] : multi_pin_2_out;
    assign multi_pin_4 = multi_pin_4_oe_n ? level[3] : multi_pin_4_out;
    assign multi_pin_5 = multi_pin_5_oe_n ? level[4] : multi_pin_5_out;
endmodule : gen_pins_model

//--- tb/general_control_and_event_regs_test.sv
// Self-checking bench for the general control and event register group
module general_control_and_event_regs_test;
    timeunit 1ns;
    timeprecision 100ps;
    import gen_ctrl_pkg::*;
    logic        clk, reset_n, read, write, waitrequest, power_state_change, prog_supply_change;
    logic        host_ctrl_req, card_bus_req, host_ctrl_gnt, card_bus_gnt, event_out_n, g;
    logic        host_controller_off, host_controller_enable, power_switch_type;
    logic        multi_pin_0, multi_pin_1, multi_pin_2, multi_pin_4, multi_pin_5;
    logic        multi_pin_2_out, multi_pin_4_out, multi_pin_5_out;
    logic        multi_pin_2_oe_n, multi_pin_4_oe_n, multi_pin_5_oe_n;
    logic [1:0]  arbitration_select;
    logic [3:0]  byteenable;
    logic [4:0]  level;
    logic [9:0]  address;
    logic [9:0]  addrs [5] = '{10'h218, 10'h220, 10'h224, 10'h228, 10'h300};
    logic [31:0] writedata, readdata, q, seed;
    int          n_mismatch, comparisons, cycles;

    general_control_and_event_regs u_general_control_and_event_regs (.*);
    gen_pins_model u_gen_pins_model (.*);

    // Clock and hang guard
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_mismatch++;
            final_report();
        end
    end

    // Random source and expected values
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    function automatic logic [31:0] arb_exp(input int m, input logic h);
        return (m == 0) ? 32'h2 : (m == 1) ? 32'h1 : {30'h0, !h, h};
    endfunction : arb_exp

    // One Avalon cycle, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] wd);
        @(posedge clk);
        read      <= !wr;
        write     <= wr;
        address   <= a;
        writedata <= wd;
        // Values read here are those that stood just before this rising edge
        do @(posedge clk); while (waitrequest !== 1'b0);
        q = readdata;
        read  <= 1'b0;
        write <= 1'b0;
    endtask : bus
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report

    // Main sequence
    initial begin
        {reset_n, read, write, power_state_change, prog_supply_change} = '0;
        {host_ctrl_req, card_bus_req, address, writedata, level, cycles} = '0;
        {n_mismatch, comparisons} = '0;
        byteenable = 4'hF;
        seed = 32'h0B548156;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        // Reset values and an unmapped index
        foreach (addrs[i]) begin
            bus(1'b0, addrs[i], 32'h0);
            chk(q, 32'h0);
        end
        // Random control, enable and input words
        repeat (8) begin
            seed = xs(seed);
            bus(1'b1, 10'h218, seed);
            @(posedge clk);
            chk(32'(power_switch_type), 32'(seed[10]));
            chk(32'(arbitration_select), 32'(seed[1:0]));
            chk(32'(host_controller_off), 32'(seed[3]));
            bus(1'b0, 10'h218, 32'h0);
            chk(q, seed & {16'h0, GEN_CTRL_MASK});
            bus(1'b1, 10'h224, seed);
            bus(1'b0, 10'h224, 32'h0);
            chk(q, {24'h0, seed[7:0] & EVENT_MASK});
            level <= seed[20:16];
            repeat (3) @(posedge clk);
            bus(1'b1, 10'h228, 32'hFFFFFFFF);
            bus(1'b0, 10'h228, 32'h0);
            chk(q, {27'h0, seed[20:16]});
        end
        // Contended grants in every mode, then the controller switched off
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, 10'h218, 32'(m));
            host_ctrl_req <= 1'b1;
            card_bus_req  <= 1'b1;
            repeat (2) @(posedge clk);
            @(negedge clk) g = host_ctrl_gnt;
            @(negedge clk);
            chk(32'({host_ctrl_gnt, card_bus_gnt}), arb_exp(m, g));
        end
        card_bus_req <= 1'b0;
        bus(1'b1, 10'h218, 32'h8);
        repeat (2) @(posedge clk);
        chk(32'({host_ctrl_gnt, host_controller_enable}), 32'h0);
        bus(1'b1, 10'h218, 32'h0);
        repeat (2) @(posedge clk);
        chk(32'(host_ctrl_gnt), 32'h1);
        // Pin changes, supply notices, masking and write-one clear
        bus(1'b1, 10'h224, 32'hFF);
        bus(1'b1, 10'h220, 32'hFF);
        level <= ~level;
        repeat (3) @(posedge clk);
        power_state_change <= 1'b1;
        prog_supply_change <= 1'b1;
        @(posedge clk);
        power_state_change <= 1'b0;
        prog_supply_change <= 1'b0;
        bus(1'b0, 10'h220, 32'h0);
        chk(q, 32'hDF);
        chk(32'(event_out_n), 32'h0);
        bus(1'b1, 10'h220, 32'h01);
        bus(1'b0, 10'h220, 32'h0);
        chk(q, 32'hDE);
        bus(1'b1, 10'h224, 32'h01);
        @(posedge clk);
        chk(32'(event_out_n), 32'h1);
        bus(1'b1, 10'h224, 32'hFF);
        @(posedge clk);
        chk(32'(event_out_n), 32'h0);
        bus(1'b1, 10'h220, 32'hFF);
        @(posedge clk);
        chk(32'(event_out_n), 32'h1);
        // Pin 0 off input duty, pin 5 carrying the event output
        bus(1'b1, 10'h240, 32'hE0001);
        level <= level ^ 5'h03;
        repeat (4) @(posedge clk);
        chk(32'({multi_pin_5_oe_n, multi_pin_5_out}), 32'h0);
        bus(1'b0, 10'h220, 32'h0);
        chk(q, 32'h02);
        final_report();
    end
endmodule : general_control_and_event_regs_test
